/* hw/tsrb_pkg.sv */
/*
 * tsrb_pkg: register numbers, field positions and constants for the
 * tile status register bank.
 * assumes: processor-status accesses carry an 8-bit register number.
 */
package tsrb_pkg;

	localparam int unsigned TSRB_DATA_W = 32;
	localparam int unsigned TSRB_ADDR_W = 8;
	localparam int unsigned TSRB_RO_W = 16;
	localparam int unsigned TSRB_RO_NUM = 4;

	typedef logic [TSRB_ADDR_W-1:0] tsrb_addr_t;
	typedef logic [TSRB_DATA_W-1:0] tsrb_word_t;
	typedef logic [TSRB_RO_W-1:0] tsrb_count_t;

	// register numbers
	localparam tsrb_addr_t TSRB_BOOT_STATUS = 8'h03;
	localparam tsrb_addr_t TSRB_SECURITY_CONFIG = 8'h05;
	localparam tsrb_addr_t TSRB_RING_OSC_CONTROL = 8'h06;
	localparam tsrb_addr_t TSRB_RING_COUNT_TILE_CELL = 8'h07;
	localparam tsrb_addr_t TSRB_RING_COUNT_TILE_WIRE = 8'h08;
	localparam tsrb_addr_t TSRB_RING_COUNT_PERIPH_CELL = 8'h09;
	localparam tsrb_addr_t TSRB_RING_COUNT_PERIPH_WIRE = 8'h0a;
	localparam tsrb_addr_t TSRB_RAM_SIZE = 8'h0c;
	localparam tsrb_addr_t TSRB_DEBUG_SAVED_STATUS = 8'h10;
	localparam tsrb_addr_t TSRB_DEBUG_SAVED_PC = 8'h11;
	localparam tsrb_addr_t TSRB_DEBUG_SAVED_SP = 8'h12;
	localparam tsrb_addr_t TSRB_DEBUG_FETCH_THREAD_SEL = 8'h13;

	// boot status fields
	localparam int unsigned TSRB_BOOT_PROC_LSB = 16;
	localparam int unsigned TSRB_BOOT_PROC_W = 8;
	localparam int unsigned TSRB_BOOT_OVERRIDE_BIT = 8;
	localparam int unsigned TSRB_BOOT_CORE1_OFF_BIT = 5;
	localparam int unsigned TSRB_BOOT_NO_POLL_BIT = 4;
	localparam int unsigned TSRB_BOOT_FROM_RAM_BIT = 3;
	localparam int unsigned TSRB_BOOT_FROM_JTAG_BIT = 2;
	localparam int unsigned TSRB_BOOT_PLL_LSB = 0;
	localparam int unsigned TSRB_BOOT_PLL_W = 2;

	// security fields
	localparam int unsigned TSRB_SEC_WRITE_LOCK_BIT = 31;
	localparam int unsigned TSRB_SEC_NO_GLOBAL_DEBUG_BIT = 14;
	localparam int unsigned TSRB_SEC_LOCK_ALL_BIT = 12;
	localparam int unsigned TSRB_SEC_SECTOR_LSB = 8;
	localparam int unsigned TSRB_SEC_SECTOR_W = 4;
	localparam int unsigned TSRB_SEC_REDUNDANCY_BIT = 7;
	localparam int unsigned TSRB_SEC_BOOT_OTP_BIT = 5;
	localparam int unsigned TSRB_SEC_NO_JTAG_CFG_BIT = 4;
	localparam int unsigned TSRB_SEC_NO_JTAG_TAP_BIT = 0;
	localparam tsrb_word_t TSRB_SEC_WRITABLE = 32'h80005fb1;

	// ring oscillator control
	localparam int unsigned TSRB_RO_CORE_EN_BIT = 1;
	localparam int unsigned TSRB_RO_PERIPH_EN_BIT = 0;
	localparam logic [1:0] TSRB_RO_CTRL_RESET = 2'h0;
	localparam int unsigned TSRB_RO_SYNC_STAGES = 2;

	// ram size
	localparam int unsigned TSRB_RAM_SIZE_LSB = 2;

	// saved status word fields
	localparam int unsigned TSRB_SSW_ADDR_SPACE_BIT = 10;
	localparam int unsigned TSRB_SSW_KENTRY_DI_BIT = 9;
	localparam int unsigned TSRB_SSW_DUAL_ISSUE_BIT = 8;
	localparam int unsigned TSRB_SSW_FAST_BIT = 7;
	localparam int unsigned TSRB_SSW_PAUSED_BIT = 6;
	localparam int unsigned TSRB_SSW_KERNEL_BIT = 4;
	localparam int unsigned TSRB_SSW_IN_INT_BIT = 3;
	localparam int unsigned TSRB_SSW_IN_EEBLE_BIT = 2;
	localparam int unsigned TSRB_SSW_INT_EN_BIT = 1;
	localparam int unsigned TSRB_SSW_EVT_EN_BIT = 0;
	localparam tsrb_word_t TSRB_SSW_STORED = 32'h000007df;
	localparam tsrb_word_t TSRB_SSW_WRITABLE = 32'h000006df;

	localparam int unsigned TSRB_THREAD_SEL_W = 8;

	// load sequencer states, gray along the path
	typedef enum logic [1:0] {
		TSRB_ST_LOAD = 2'h0,
		TSRB_ST_WAIT_OTP = 2'h1,
		TSRB_ST_RUN = 2'h3
	} tsrb_state_t;

endpackage

/* hw/tsrb_ring_counter.sv */
/*
 * tsrb_ring_counter: one free-running ring oscillator counter, clocked
 * by its own oscillator and gated by a synchronised enable.
 * assumes: oscClk is free running; enable comes from the tile clock.
 */
`timescale 1ns/10ps
`default_nettype none

module tsrb_ring_counter
	import tsrb_pkg::*;
(
	input wire logic oscClk, // ring oscillator output
	input wire logic enable, // run request, tile clock domain
	output tsrb_pkg::tsrb_count_t count // running count, oscillator domain
);

	// power-up values only, so the count never starts unknown
	logic [TSRB_RO_SYNC_STAGES-1:0] enSync_reg = 2'h0;
	tsrb_count_t count_reg = 16'h0000;

	// no reset here: the count survives a system reset
	always_ff @(posedge oscClk)
	begin
		enSync_reg <= {enSync_reg[0], enable};
	end

	always_ff @(posedge oscClk)
	begin
		if (enSync_reg[1])
		begin
			count_reg <= count_reg + 16'h0001;
		end
	end

	assign count = count_reg;

endmodule

`default_nettype wire

/* hw/tsrb_top.sv */
/*
 * tsrb_top: tile status register bank reached by processor-status reads
 * and writes: boot status, security copy, ring oscillators, ram size,
 * debug saved state and debug fetch thread selector.
 * assumes: one tile clock; strap, otp and debug inputs static or on clk.
 */
`timescale 1ns/10ps
`default_nettype none

module tsrb_top
	import tsrb_pkg::*;
#(
	parameter tsrb_pkg::tsrb_word_t RAM_BYTES = 32'h00080000
)
(
	input wire logic clk, // tile clock
	input wire logic srst, // synchronous reset
	input wire logic psRead, // status read strobe
	input wire logic psWrite, // status write strobe
	input wire tsrb_pkg::tsrb_addr_t psNum, // register number
	input wire tsrb_pkg::tsrb_word_t psWdata, // write data
	output tsrb_pkg::tsrb_word_t psRdata, // read data, registered
	output logic psAck, // access done pulse
	output logic psError, // unmapped or refused pulse
	input wire logic [7:0] procNumber, // processor number
	input wire logic [1:0] pllModePin, // pll mode pins
	input wire logic bootOverride, // boot mode override strap
	input wire logic core1Off, // second core powered off
	input wire logic otpNoPoll, // skip otp level polling
	input wire logic bootFromRam, // boot rom boots from ram
	input wire logic bootFromJtag, // boot rom boots over jtag
	input wire tsrb_pkg::tsrb_word_t otpSecurity, // security word from otp
	input wire logic otpValid, // otp word available
	output logic coreStart, // processor may run
	input wire logic [3:0] ringOscClk, // four oscillator clocks
	output logic ringCoreEn, // core oscillator enable
	output logic ringPeriphEn, // peripheral oscillator enable
	output logic globalDebugDisable, // global debug blocked
	output logic jtagTapDisable, // jtag debug tap blocked
	output logic otpLockAll, // all otp sectors locked
	output logic [3:0] otpSectorLock, // per sector locks
	output logic otpRedundancy, // otp redundancy on
	output logic bootFromOtp, // boot image from otp
	output logic jtagCfgDisable, // jtag blocked from pll/boot regs
	input wire logic debugMode, // core in debug mode
	input wire logic debugEnter, // debugger invoked pulse
	input wire tsrb_pkg::tsrb_word_t liveStatus, // thread status word
	input wire tsrb_pkg::tsrb_word_t livePc, // thread program counter
	input wire tsrb_pkg::tsrb_word_t liveSp, // thread stack pointer
	output logic [7:0] fetchThread // thread for register fetch
);

	tsrb_state_t state_reg;
	tsrb_state_t state_next;
	tsrb_word_t bootStatus_reg;
	tsrb_word_t security_reg;
	logic [1:0] roCtrl_reg;
	tsrb_word_t savedStatus_reg;
	tsrb_word_t savedPc_reg;
	tsrb_word_t savedSp_reg;
	logic [7:0] threadSel_reg;
	logic [1:0] otpSync_reg;
	tsrb_count_t roCount [TSRB_RO_NUM];
	tsrb_count_t roCountSync1_reg [TSRB_RO_NUM];
	tsrb_count_t roCountSync2_reg [TSRB_RO_NUM];
	logic running;
	logic wrSec;
	logic wrDbg;
	logic mapped;
	logic refused;

	////////////////////////////////////////////////////////////////////////
	// functions

	function automatic logic isMapped(input tsrb_addr_t n);
		case (n)
			TSRB_BOOT_STATUS, TSRB_SECURITY_CONFIG, TSRB_RING_OSC_CONTROL,
			TSRB_RING_COUNT_TILE_CELL, TSRB_RING_COUNT_TILE_WIRE,
			TSRB_RING_COUNT_PERIPH_CELL, TSRB_RING_COUNT_PERIPH_WIRE,
			TSRB_RAM_SIZE, TSRB_DEBUG_SAVED_STATUS, TSRB_DEBUG_SAVED_PC,
			TSRB_DEBUG_SAVED_SP, TSRB_DEBUG_FETCH_THREAD_SEL:
				isMapped = 1'b1;
			default:
				isMapped = 1'b0;
		endcase
	endfunction

	function automatic logic isDebugReg(input tsrb_addr_t n);
		isDebugReg = (n == TSRB_DEBUG_SAVED_STATUS) ||
			(n == TSRB_DEBUG_SAVED_PC) || (n == TSRB_DEBUG_SAVED_SP) ||
			(n == TSRB_DEBUG_FETCH_THREAD_SEL);
	endfunction

	// masked merge of write data into a word
	function automatic tsrb_word_t merge(input tsrb_word_t old,
		input tsrb_word_t wd, input tsrb_word_t mask);
		merge = (old & ~mask) | (wd & mask);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// load sequence: straps, then otp, then run

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			TSRB_ST_LOAD:
				state_next = TSRB_ST_WAIT_OTP;
			TSRB_ST_WAIT_OTP:
				if (otpSync_reg[1])
				begin
					state_next = TSRB_ST_RUN;
				end
			TSRB_ST_RUN:
				state_next = TSRB_ST_RUN;
			default:
				state_next = TSRB_ST_LOAD;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			state_reg <= TSRB_ST_LOAD;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			otpSync_reg <= 2'h0;
		end
		else
		begin
			otpSync_reg <= {otpSync_reg[0], otpValid};
		end
	end

	assign running = (state_reg == TSRB_ST_RUN);
	assign coreStart = running;

	////////////////////////////////////////////////////////////////////////
	// boot status, straps caught after reset release

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			bootStatus_reg <= 32'h00000000;
		end
		else if (state_reg == TSRB_ST_LOAD)
		begin
			bootStatus_reg <= 32'h00000000;
			bootStatus_reg[TSRB_BOOT_PROC_LSB +: TSRB_BOOT_PROC_W] <=
				procNumber;
			bootStatus_reg[TSRB_BOOT_OVERRIDE_BIT] <= bootOverride;
			bootStatus_reg[TSRB_BOOT_PLL_LSB +: TSRB_BOOT_PLL_W] <=
				pllModePin;
			bootStatus_reg[TSRB_BOOT_FROM_RAM_BIT] <= bootFromRam;
			bootStatus_reg[TSRB_BOOT_FROM_JTAG_BIT] <= bootFromJtag;
			bootStatus_reg[TSRB_BOOT_CORE1_OFF_BIT] <= core1Off;
			bootStatus_reg[TSRB_BOOT_NO_POLL_BIT] <= otpNoPoll;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// write decode

	assign mapped = isMapped(psNum);
	assign wrSec = psWrite && running && (psNum == TSRB_SECURITY_CONFIG) &&
		!security_reg[TSRB_SEC_WRITE_LOCK_BIT];
	assign wrDbg = psWrite && running && isDebugReg(psNum) &&
		debugMode;
	assign refused = !mapped ||
		(psWrite && (psNum == TSRB_SECURITY_CONFIG) && !wrSec) ||
		(psWrite && isDebugReg(psNum) && !wrDbg);

	////////////////////////////////////////////////////////////////////////
	// security configuration

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			security_reg <= 32'h00000000;
		end
		else if (state_reg == TSRB_ST_WAIT_OTP && otpSync_reg[1])
		begin
			security_reg <= otpSecurity & TSRB_SEC_WRITABLE;
		end
		else if (wrSec)
		begin
			security_reg <= merge(security_reg, psWdata,
				TSRB_SEC_WRITABLE);
		end
	end

	assign globalDebugDisable = security_reg[TSRB_SEC_NO_GLOBAL_DEBUG_BIT];
	assign jtagTapDisable = security_reg[TSRB_SEC_NO_JTAG_TAP_BIT];
	assign otpLockAll = security_reg[TSRB_SEC_LOCK_ALL_BIT];
	assign otpSectorLock = security_reg[TSRB_SEC_SECTOR_LSB +:
		TSRB_SEC_SECTOR_W] | {TSRB_SEC_SECTOR_W{otpLockAll}};
	assign otpRedundancy = security_reg[TSRB_SEC_REDUNDANCY_BIT];
	assign bootFromOtp = security_reg[TSRB_SEC_BOOT_OTP_BIT];
	assign jtagCfgDisable = security_reg[TSRB_SEC_NO_JTAG_CFG_BIT];

	////////////////////////////////////////////////////////////////////////
	// ring oscillators

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			roCtrl_reg <= TSRB_RO_CTRL_RESET;
		end
		else if (psWrite && running && psNum == TSRB_RING_OSC_CONTROL)
		begin
			roCtrl_reg <= psWdata[1:0];
		end
	end

	assign ringCoreEn = roCtrl_reg[TSRB_RO_CORE_EN_BIT];
	assign ringPeriphEn = roCtrl_reg[TSRB_RO_PERIPH_EN_BIT];

	// counters 0,1 tile cell and wire on core enable; 2,3 on periph enable
	genvar gi;
	generate
		for (gi = 0; gi < TSRB_RO_NUM; gi++)
		begin : gRing
			tsrb_ring_counter uCount (
				.oscClk(ringOscClk[gi]),
				.enable(gi < 2 ? ringCoreEn : ringPeriphEn),
				.count(roCount[gi])
			);
		end
	endgenerate

	// counts are stable once stopped; software waits before reading
	// no reset, so the count survives a system reset
	always_ff @(posedge clk)
	begin
		for (int i = 0; i < TSRB_RO_NUM; i++)
		begin
			roCountSync1_reg[i] <= roCount[i];
			roCountSync2_reg[i] <= roCountSync1_reg[i];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// debug saved state and fetch thread selector

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			savedStatus_reg <= 32'h00000000;
			savedPc_reg <= 32'h00000000;
			savedSp_reg <= 32'h00000000;
		end
		else if (debugEnter)
		begin
			savedStatus_reg <= liveStatus & TSRB_SSW_STORED;
			savedPc_reg <= livePc;
			savedSp_reg <= liveSp;
		end
		else if (wrDbg)
		begin
			if (psNum == TSRB_DEBUG_SAVED_STATUS)
			begin
				savedStatus_reg <= merge(savedStatus_reg, psWdata,
					TSRB_SSW_WRITABLE);
			end
			if (psNum == TSRB_DEBUG_SAVED_PC)
			begin
				savedPc_reg <= psWdata;
			end
			if (psNum == TSRB_DEBUG_SAVED_SP)
			begin
				savedSp_reg <= psWdata;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			threadSel_reg <= 8'h00;
		end
		else if (wrDbg && psNum == TSRB_DEBUG_FETCH_THREAD_SEL)
		begin
			threadSel_reg <= psWdata[TSRB_THREAD_SEL_W-1:0];
		end
	end

	assign fetchThread = threadSel_reg;

	////////////////////////////////////////////////////////////////////////
	// read port, addressed by register number

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			psRdata <= 32'h00000000;
			psAck <= 1'b0;
			psError <= 1'b0;
		end
		else
		begin
			psAck <= (psRead || psWrite) && running;
			psError <= (psRead || psWrite) && running && refused;
			if (psRead && running)
			begin
				case (psNum)
					TSRB_BOOT_STATUS:
						psRdata <= bootStatus_reg;
					TSRB_SECURITY_CONFIG:
						psRdata <= security_reg;
					TSRB_RING_OSC_CONTROL:
						psRdata <= {30'h0, roCtrl_reg};
					TSRB_RING_COUNT_TILE_CELL:
						psRdata <= {16'h0000, roCountSync2_reg[0]};
					TSRB_RING_COUNT_TILE_WIRE:
						psRdata <= {16'h0000, roCountSync2_reg[1]};
					TSRB_RING_COUNT_PERIPH_CELL:
						psRdata <= {16'h0000, roCountSync2_reg[2]};
					TSRB_RING_COUNT_PERIPH_WIRE:
						psRdata <= {16'h0000, roCountSync2_reg[3]};
					TSRB_RAM_SIZE:
						psRdata <= {RAM_BYTES[31:TSRB_RAM_SIZE_LSB],
							2'h0};
					TSRB_DEBUG_SAVED_STATUS:
						psRdata <= savedStatus_reg;
					TSRB_DEBUG_SAVED_PC:
						psRdata <= savedPc_reg;
					TSRB_DEBUG_SAVED_SP:
						psRdata <= savedSp_reg;
					TSRB_DEBUG_FETCH_THREAD_SEL:
						psRdata <= {24'h000000, threadSel_reg};
					default:
						psRdata <= 32'h00000000;
				endcase
			end
		end
	end

endmodule

`default_nettype wire

/* verification/tsrb_top_monitor.sv */
/* tsrb_top_monitor: port checks of the tile status register bank.
 assumes: bound into tsrb_top, one clock, srst synchronous. */
`timescale 1ns/10ps
`default_nettype none
module tsrb_top_monitor
	import tsrb_pkg::*;
#(
	parameter tsrb_pkg::tsrb_word_t RAM_BYTES = 32'h00080000
)
(
	input wire logic clk, // tile clock
	input wire logic srst, // sync reset
	input wire logic psRead, // read strobe
	input wire logic psWrite, // write strobe
	input wire tsrb_pkg::tsrb_addr_t psNum, // register number
	input wire tsrb_pkg::tsrb_word_t psWdata, // write data
	input wire tsrb_pkg::tsrb_word_t psRdata, // read data
	input wire logic psAck, // done pulse
	input wire logic psError, // error pulse
	input wire logic coreStart, // loaded
	input wire logic debugMode, // debug mode
	input wire logic ringCoreEn, // core osc enable
	input wire logic ringPeriphEn, // periph osc enable
	input wire logic otpLockAll, // lock all
	input wire logic [3:0] otpSectorLock, // sector locks
	input wire logic [7:0] fetchThread // thread selector
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	logic take;
	assign take = (psRead | psWrite) & coreStart;
	ack_timing_a: assert property (take |=> psAck)
		else $error("access not acknowledged next cycle");
	ack_idle_a: assert property (!take |=> !psAck)
		else $error("acknowledge without accepted access");
	error_ack_a: assert property (psError |-> psAck)
		else $error("error pulse without acknowledge");
	ram_read_a: assert property (take && psRead && psNum == TSRB_RAM_SIZE
		|=> psRdata == {RAM_BYTES[31:2], 2'h0})
		else $error("ram size read wrong");
	count_hi_a: assert property (take && psRead && psNum inside {[8'h07:8'h0a]}
		|=> psRdata[31:16] == 16'h0)
		else $error("count reserved bits not zero");
	osc_ctrl_a: assert property (take && psWrite
		&& psNum == TSRB_RING_OSC_CONTROL
		|=> {ringCoreEn, ringPeriphEn} == $past(psWdata[1:0]))
		else $error("oscillator enables not updated");
	thread_sel_a: assert property (take && psWrite && debugMode
		&& psNum == TSRB_DEBUG_FETCH_THREAD_SEL
		|=> fetchThread == $past(psWdata[7:0]))
		else $error("thread selector not written");
	debug_refuse_a: assert property (take && psWrite && !debugMode
		&& psNum == TSRB_DEBUG_FETCH_THREAD_SEL
		|=> psError && $stable(fetchThread))
		else $error("debug write outside debug mode");
	lock_all_a: assert property (otpLockAll |-> otpSectorLock == 4'hf)
		else $error("lock all not on sector locks");
endmodule
bind tsrb_top tsrb_top_monitor #(.RAM_BYTES(RAM_BYTES)) monitor (.*);
`default_nettype wire

/* verification/tb_tsrb_top.sv */
/* tb_tsrb_top: self-checking bench of the tile status register bank.
 assumes: tsrb_top and tsrb_pkg compiled first. */
`timescale 1ns/10ps
`default_nettype none
module tb_tsrb_top;
	import tsrb_pkg::*;
	localparam tsrb_word_t RAM_B = 32'h00040003;
	logic clk = 0, srst = 1, psRead = 0, psWrite = 0, otpValid = 0;
	logic debugMode = 0, debugEnter = 0, psAck, psError, coreStart;
	logic bootOverride, core1Off, otpNoPoll, bootFromRam, bootFromJtag;
	logic ringCoreEn, ringPeriphEn, globalDebugDisable, jtagTapDisable;
	logic otpLockAll, otpRedundancy, bootFromOtp, jtagCfgDisable;
	logic [7:0] procNumber, fetchThread;
	logic [1:0] pllModePin;
	logic [3:0] ringOscClk = 4'h0, otpSectorLock;
	tsrb_addr_t psNum = 8'h00;
	tsrb_word_t psWdata = 32'h0, psRdata, otpSecurity, liveStatus, livePc;
	tsrb_word_t liveSp, rd, w;
	tsrb_word_t secv [4];
	tsrb_word_t cnt [4];
	logic er;
	int n_mismatch = 0, samples_checked = 0, cycles = 0;
	int seed = 32'h79f6dc83;
	tsrb_top #(.RAM_BYTES(RAM_B)) dut (.*);
	always #12.5 clk = ~clk;
	// free-running oscillators, unrelated to clk
	always #7 ringOscClk[0] = ~ringOscClk[0];
	always #9 ringOscClk[1] = ~ringOscClk[1];
	always #11 ringOscClk[2] = ~ringOscClk[2];
	always #13 ringOscClk[3] = ~ringOscClk[3];
	////////////////////////////////////////////////////////////////////////
	task give_verdict;
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 6000)
		begin
			n_mismatch++;
			give_verdict;
		end
	end
	task check(input string nm, input tsrb_word_t e, input tsrb_word_t g);
		samples_checked++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task acc(input logic r, input logic wr, input tsrb_addr_t n,
		input tsrb_word_t d);
		@(negedge clk);
		psRead = r;
		psWrite = wr;
		psNum = n;
		psWdata = d;
		@(negedge clk);
		psRead = 0;
		psWrite = 0;
		check("ack", 32'h1, {31'h0, psAck});
		rd = psRdata;
		er = psError;
	endtask
	task rchk(input tsrb_addr_t n, input tsrb_word_t e);
		acc(1'b1, 1'b0, n, 32'h0);
		check("read", e, rd);
		check("read error", 32'h0, {31'h0, er});
	endtask
	task wchk(input tsrb_addr_t n, input tsrb_word_t d, input logic e);
		acc(1'b0, 1'b1, n, d);
		check("write error", {31'h0, e}, {31'h0, er});
	endtask
	task sec_chk(input tsrb_word_t s);
		check("security outputs", {22'h0, s[14], s[0], s[12],
			s[11:8] | {4{s[12]}}, s[7], s[5], s[4]},
			{22'h0, globalDebugDisable, jtagTapDisable, otpLockAll,
			otpSectorLock, otpRedundancy, bootFromOtp, jtagCfgDisable});
	endtask
	task do_reset;
		@(negedge clk);
		srst = 1;
		repeat (20) @(negedge clk);
		srst = 0;
		repeat (8) if (!coreStart) @(negedge clk);
		check("start", 32'h1, {31'h0, coreStart});
	endtask
	function automatic tsrb_word_t boot_exp();
		return {8'h0, procNumber, 7'h0, bootOverride, 2'h0, core1Off,
			otpNoPoll, bootFromRam, bootFromJtag, pllModePin};
	endfunction
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		{procNumber, pllModePin, bootOverride, core1Off, otpNoPoll,
			bootFromRam, bootFromJtag} = 15'($random(seed));
		otpSecurity = $random(seed) & 32'h7fffffff;
		liveStatus = $random(seed);
		livePc = $random(seed);
		liveSp = $random(seed);
		repeat (20) @(negedge clk);
		srst = 0;
		// access before the otp word lands is not taken
		psRead = 1;
		psNum = TSRB_BOOT_STATUS;
		@(negedge clk);
		psRead = 0;
		@(negedge clk);
		check("early ack", 32'h0, {31'h0, psAck | coreStart});
		otpValid = 1;
		repeat (8) if (!coreStart) @(negedge clk);
		rchk(TSRB_BOOT_STATUS, boot_exp());
		wchk(TSRB_BOOT_STATUS, 32'hffffffff, 1'b0);
		rchk(TSRB_BOOT_STATUS, boot_exp());
		rchk(TSRB_SECURITY_CONFIG, otpSecurity & TSRB_SEC_WRITABLE);
		sec_chk(otpSecurity & TSRB_SEC_WRITABLE);
		secv = '{32'h00001000, 32'h00004f81, $random(seed) & 32'h7fffffff,
			32'hffffffff};
		for (int i = 0; i < 4; i++)
		begin
			wchk(TSRB_SECURITY_CONFIG, secv[i], 1'b0);
			rchk(TSRB_SECURITY_CONFIG, secv[i] & TSRB_SEC_WRITABLE);
			sec_chk(secv[i] & TSRB_SEC_WRITABLE);
		end
		wchk(TSRB_SECURITY_CONFIG, 32'h0, 1'b1);
		rchk(TSRB_SECURITY_CONFIG, TSRB_SEC_WRITABLE);
		acc(1'b1, 1'b0, 8'h04, 32'h0);
		check("unmapped", 32'h1, {rd[30:0], er});
		wchk(TSRB_RAM_SIZE, 32'hffffffff, 1'b0);
		rchk(TSRB_RAM_SIZE, RAM_B & 32'hfffffffc);
		rchk(TSRB_RING_OSC_CONTROL, 32'h0);
		for (int i = 1; i < 5; i++)
		begin
			wchk(TSRB_RING_OSC_CONTROL, 32'(i & 3), 1'b0);
			check("osc en", 32'(i & 3), {30'h0, ringCoreEn, ringPeriphEn});
			repeat (10) @(negedge clk);
		end
		for (int i = 0; i < 4; i++)
		begin
			acc(1'b1, 1'b0, 8'(8'h07 + i), 32'h0);
			check("count hi", 32'h0, rd & 32'hffff0000);
			check("count ran", 32'h1, {31'h0, rd[15:0] != 16'h0});
			cnt[i] = rd;
		end
		do_reset();
		rchk(TSRB_SECURITY_CONFIG, otpSecurity & TSRB_SEC_WRITABLE);
		for (int i = 0; i < 4; i++)
			rchk(8'(8'h07 + i), cnt[i]);
		@(negedge clk);
		debugEnter = 1;
		@(negedge clk);
		debugEnter = 0;
		rchk(TSRB_DEBUG_SAVED_STATUS, liveStatus & TSRB_SSW_STORED);
		rchk(TSRB_DEBUG_SAVED_PC, livePc);
		rchk(TSRB_DEBUG_SAVED_SP, liveSp);
		wchk(TSRB_DEBUG_FETCH_THREAD_SEL, 32'h5a, 1'b1);
		wchk(TSRB_DEBUG_SAVED_PC, 32'h0, 1'b1);
		rchk(TSRB_DEBUG_SAVED_PC, livePc);
		debugMode = 1;
		w = $random(seed);
		wchk(TSRB_DEBUG_FETCH_THREAD_SEL, w, 1'b0);
		check("thread", {24'h0, w[7:0]}, {24'h0, fetchThread});
		rchk(TSRB_DEBUG_FETCH_THREAD_SEL, {24'h0, w[7:0]});
		wchk(TSRB_DEBUG_SAVED_STATUS, w, 1'b0);
		rchk(TSRB_DEBUG_SAVED_STATUS, (w & TSRB_SSW_WRITABLE)
			| (liveStatus & 32'h100));
		wchk(TSRB_DEBUG_SAVED_SP, ~w, 1'b0);
		rchk(TSRB_DEBUG_SAVED_SP, ~w);
		give_verdict;
	end
endmodule
`default_nettype wire
